// *** rtl/wdt_cfg.svh ***
// Register indices, field positions, reset values and counts for the watchdog and sleep controller
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define STAT_IDX        14'h0003
`define OPT_IDX         14'h0081
`define VADDR_IDX       14'h0010
`define VDATA_IDX       14'h0011
`define ID_IDX          14'h2000
`define ID_MASK         14'h3ffc
`define CFG_IDX         14'h2007

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define OPT_PSA         3
`define OPT_RATE_HI     2
`define OPT_RATE_LO     0
`define CFG_DEBUG       7
`define CFG_CP_HI       5
`define CFG_CP_LO       4
`define CFG_WATCHDOG_ENABLE_CFG        2
`define STAT_TO         4
`define STAT_PD         3

// ---------------------------------------------------------------
// Reset values and sizes
// ---------------------------------------------------------------
`define OPT_RESET       8'hff
`define CFG_RESET       8'hff
`define CP_OFF          2'b11
`define PROG_WORDS      14'h2000
`define DEBUG_WORDS     14'h0100
`define WDT_BASE_DEF    16'h0400
`define NUM_WAKE        12

`endif

// *** rtl/wdt_pkg.sv ***
// Types shared by the watchdog and sleep controller
`default_nettype none

package wdt_pkg;

    // ---------------------------------------------------------------
    // Operating modes
    // ---------------------------------------------------------------
    typedef enum logic [0:0] {
        MODE_RUN   = 1'b0,
        MODE_SLEEP = 1'b1
    } mode_type;

    // ---------------------------------------------------------------
    // Whole state of the controller
    // ---------------------------------------------------------------
    typedef struct packed {
        mode_type          mode;
        logic [7:0]        option;
        logic [7:0]        cfg_word;
        logic [3:0][13:0]  id_word;
        logic [12:0]       verify_addr;
        logic [15:0]       wdt_base;
        logic [7:0]        wdt_post;
        logic [7:0]        tmr0_pre;
        logic              to_n;
        logic              pd_n;
        logic              wdt_reset;
        logic              device_reset;
        logic              wake;
        logic              vector;
        logic              tmr0_en;
        logic [31:0]       prdata;
        logic              pslverr;
        logic [13:0]       ser_shift;
        logic              ser_clk_q;
        logic              ser_load;
    } state_type;

endpackage

`default_nettype wire

// *** rtl/watchdog_sleep_wake_control.sv ***
// Watchdog timer, shared prescaler and sleep/wake controller with APB register access
//
// Overview of operation
// - Watchdog counts ticks of its own oscillator, also while the core clock stops.
// - Expiry while running issues a full watchdog device reset.
// - Expiry while sleeping wakes the device and execution continues.
// - Every watchdog expiry without a master clear in the same cycle clears the active-low time-out flag, status bit 4.
// - Cleared enable bit 2 of configuration disables the watchdog; software cannot restore it.
// - One prescaler shared by watchdog and timer 0; bit 3 owner, bits 2..0 rate.
// - Clear-watchdog or sleep zeroes watchdog count, and postscaler when it owns it.
// - Clear-watchdog zeroes the prescaler count only while the watchdog owns it, and leaves the assignment bit alone.
// - Sleep entry clears watchdog, clears power-down, sets time-out, stops oscillator driver.
// - During sleep every I/O pin holds its previous drive state.
// - Master clear in sleep resets; watchdog or enabled interrupts wake instead.
// - Power-down flag is set at power-up and cleared by each sleep.
// - Only the twelve clock-free sources can wake; others are not connected.
// - A source wakes only with its own enable set, independent of global enable.
// - After wake the next instruction runs, then vector if global enable set.
// - Sleep with enabled interrupt already pending is a no-op, flags untouched.
// - Interrupt during or after sleep: sleep completes fully, then wakes at once.
// - Debug bit at 0 reserves two port pins, stack level, last 100h words.
// - Four ID words reachable only in program/verify mode; low four bits advised.
// - Program memory verify read allowed only while code protection is off.
// - Serial programming uses an external clock line and a two-way data line.
`timescale 1ns/100ps
`default_nettype none
`include "wdt_cfg.svh"

module watchdog_sleep_wake_control
    import wdt_pkg::*;
#(
    parameter logic [15:0] WDT_BASE_TICKS = `WDT_BASE_DEF
)
(
    input  wire logic                  pclk,                  // Core clock, 40 MHz
    input  wire logic                  presetn,               // Power-up reset, active low
    input  wire logic                  psel,                  // APB select
    input  wire logic                  penable,               // APB access phase
    input  wire logic                  pwrite,                // APB write
    input  wire logic [15:0]           paddr,                 // APB byte address
    input  wire logic [31:0]           pwdata,                // APB write data
    output logic      [31:0]           prdata,                // APB read data
    output logic                       pready,                // APB ready
    output logic                       pslverr,               // APB error
    input  wire logic                  wdt_osc_tick,          // Watchdog oscillator tick
    input  wire logic                  tmr0_src_tick,         // Timer 0 source tick
    output logic                       tmr0_count_en,         // Prescaled timer 0 count pulse
    input  wire logic                  clear_watchdog_instr,  // Clear-watchdog executed
    input  wire logic                  sleep_instr,           // Sleep executed
    input  wire logic                  global_irq_enable,     // Global interrupt enable
    input  wire logic [`NUM_WAKE-1:0]  irq_flag,              // Wake-capable interrupt flags
    input  wire logic [`NUM_WAKE-1:0]  irq_enable,            // Their enable bits
    input  wire logic                  master_clear_pin_n,    // Master clear, active low
    input  wire logic                  prog_mode,             // Program/verify mode
    input  wire logic [13:0]           prog_mem_rdata,        // Program memory read word
    output logic      [12:0]           prog_mem_addr,         // Program memory verify address
    output logic                       core_clk_en,           // Core clock gate
    output logic                       osc_driver_en,         // Main oscillator driver on
    output logic                       io_hold,               // Freeze pin drive states
    output logic                       wake_pulse,            // Wake-up from sleep
    output logic                       branch_to_vector,      // Vector after next instruction
    output logic                       wdt_reset,             // Watchdog device reset
    output logic                       device_reset,          // Master-clear device reset
    output logic                       time_out_flag_n,       // Time-out flag
    output logic                       power_down_flag_n,     // Power-down flag
    output logic                       debug_reserve,         // Debugger resources claimed
    output logic      [13:0]           debug_mem_base,        // First reserved program word
    input  wire logic                  serial_prog_clk,       // Programmer clock line
    input  wire logic                  serial_prog_data_in,   // Data line input
    output logic                       serial_prog_data_out,  // Data line output
    output logic                       serial_prog_data_oe_n  // Data line enable, low drives
);

    // ---------------------------------------------------------------
    // State and reset value
    // ---------------------------------------------------------------
    localparam state_type ST_RESET = '{
        mode:     MODE_RUN,
        option:   `OPT_RESET,
        cfg_word: `CFG_RESET,
        to_n:     1'b1,
        pd_n:     1'b1,
        default:  '0
    };

    state_type st;
    state_type next_st;

    logic [13:0] idx;
    logic        aligned;
    logic        hit_opt;
    logic        hit_cfg;
    logic        hit_stat;
    logic        hit_id;
    logic        hit_vaddr;
    logic        hit_vdata;
    logic        mapped;
    logic        access_wr;
    logic        verify_ok;
    logic        pending;
    logic        master_clear_pin;
    logic        wdt_on;
    logic        psa_wdt;
    logic [7:0]  wdt_mask;
    logic [7:0]  t0_mask;
    logic        base_wrap;
    logic        expire;
    logic        sleep_taken;
    logic        ser_rise;
    logic [31:0] rd_word;

    // ---------------------------------------------------------------
    // Decoded conditions
    // ---------------------------------------------------------------
    // Only wake-capable flags reach this block, so others stay inert
    assign pending   = |(irq_flag & irq_enable);
    assign master_clear_pin      = !master_clear_pin_n;
    assign wdt_on    = st.cfg_word[`CFG_WATCHDOG_ENABLE_CFG];
    assign psa_wdt   = st.option[`OPT_PSA];
    assign wdt_mask  = (8'h01 << st.option[`OPT_RATE_HI:`OPT_RATE_LO]) - 8'h01;
    assign t0_mask   = {wdt_mask[6:0], 1'b1};                    // Timer 0 ratio is twice the watchdog one
    // Base period counted in oscillator ticks, independent of core mode
    assign base_wrap = wdt_on && wdt_osc_tick
                       && (st.wdt_base == WDT_BASE_TICKS - 16'h0001);
    // A clear in the same cycle wins, so a late clear still prevents expiry
    assign expire    = base_wrap && (!psa_wdt || st.wdt_post == wdt_mask)
                       && !clear_watchdog_instr;
    assign sleep_taken = sleep_instr && (st.mode == MODE_RUN) && !pending
                         && !master_clear_pin && !expire;
    assign verify_ok = prog_mode && (st.cfg_word[`CFG_CP_HI:`CFG_CP_LO] == `CP_OFF);
    assign ser_rise  = serial_prog_clk && !st.ser_clk_q;

    // ---------------------------------------------------------------
    // APB address decode
    // ---------------------------------------------------------------
    assign idx       = paddr[15:2];
    assign aligned   = (paddr[1:0] == 2'b00);
    assign hit_opt   = aligned && (idx == `OPT_IDX);
    assign hit_cfg   = aligned && (idx == `CFG_IDX);
    assign hit_stat  = aligned && (idx == `STAT_IDX);
    assign hit_id    = aligned && ((idx & `ID_MASK) == `ID_IDX);
    assign hit_vaddr = aligned && (idx == `VADDR_IDX);
    assign hit_vdata = aligned && (idx == `VDATA_IDX);
    // Hidden locations answer like unmapped ones outside program mode
    assign mapped    = hit_opt || hit_cfg || hit_stat || hit_vaddr
                       || (hit_id && prog_mode) || (hit_vdata && verify_ok);
    assign access_wr = psel && penable && pwrite && !st.pslverr;

    // Read data mux, sampled at the setup phase
    always_comb begin
        rd_word = 32'h0;
        if (hit_opt) begin
            rd_word = {24'h0, st.option};
        end else if (hit_cfg) begin
            rd_word = {24'h0, st.cfg_word};
        end else if (hit_stat) begin
            rd_word[`STAT_TO] = st.to_n;
            rd_word[`STAT_PD] = st.pd_n;
        end else if (hit_id && prog_mode) begin
            rd_word = {18'h0, st.id_word[paddr[3:2]]};
        end else if (hit_vaddr) begin
            rd_word = {19'h0, st.verify_addr};
        end else if (hit_vdata && verify_ok) begin
            rd_word = {18'h0, prog_mem_rdata};
        end
    end

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        next_st              = st;
        next_st.wdt_reset    = 1'b0;
        next_st.device_reset = 1'b0;
        next_st.wake         = 1'b0;
        next_st.vector       = 1'b0;
        next_st.tmr0_en      = 1'b0;
        next_st.ser_load     = 1'b0;
        next_st.ser_clk_q    = serial_prog_clk;

        // Watchdog base counter and postscaler keep running in both modes
        if (!wdt_on) begin
            next_st.wdt_base = 16'h0;
            next_st.wdt_post = 8'h0;
        end else if (wdt_osc_tick) begin
            if (base_wrap) begin
                next_st.wdt_base = 16'h0;
                if (psa_wdt) begin
                    next_st.wdt_post = (st.wdt_post == wdt_mask) ? 8'h0 : st.wdt_post + 8'h01;
                end
            end else begin
                next_st.wdt_base = st.wdt_base + 16'h0001;
            end
        end

        // Clear-watchdog and a taken sleep restart the whole watchdog chain
        if (clear_watchdog_instr || sleep_taken) begin
            next_st.wdt_base = 16'h0;
            if (psa_wdt) begin
                next_st.wdt_post = 8'h0;
            end
        end

        // Timer 0 gets the prescaler only when the watchdog does not own it
        if (tmr0_src_tick) begin
            if (psa_wdt) begin
                next_st.tmr0_en = 1'b1;
            end else if (st.tmr0_pre == t0_mask) begin
                next_st.tmr0_pre = 8'h0;
                next_st.tmr0_en  = 1'b1;
            end else begin
                next_st.tmr0_pre = st.tmr0_pre + 8'h01;
            end
        end

        // Sleep and wake sequencing; master clear outranks everything
        case (st.mode)
            MODE_RUN: begin
                if (master_clear_pin) begin
                    next_st.device_reset = 1'b1;
                end else if (expire) begin
                    next_st.wdt_reset = 1'b1;
                    next_st.to_n      = 1'b0;
                end else if (sleep_taken) begin
                    next_st.mode = MODE_SLEEP;
                    next_st.pd_n = 1'b0;
                    next_st.to_n = 1'b1;
                end
            end
            MODE_SLEEP: begin
                if (master_clear_pin) begin
                    next_st.device_reset = 1'b1;
                    next_st.mode         = MODE_RUN;
                end else if (expire) begin
                    next_st.to_n   = 1'b0;
                    next_st.wake   = 1'b1;
                    next_st.vector = global_irq_enable;
                    next_st.mode   = MODE_RUN;
                end else if (pending) begin
                    // Sleep already completed its effects, so wake at once
                    next_st.wake   = 1'b1;
                    next_st.vector = global_irq_enable;
                    next_st.mode   = MODE_RUN;
                end
            end
            default: begin
                next_st.mode = MODE_RUN;
            end
        endcase

        // APB setup phase: capture answer so read data comes from flops
        if (psel && !penable) begin
            next_st.prdata  = rd_word;
            next_st.pslverr = !mapped;
        end

        // APB access phase: writes take effect here
        if (access_wr) begin
            if (hit_opt) begin
                next_st.option = pwdata[7:0];
            end
            if (hit_cfg && prog_mode) begin
                // Normal code cannot touch configuration, so a disabled watchdog stays off
                next_st.cfg_word = pwdata[7:0];
            end
            if (hit_id && prog_mode) begin
                next_st.id_word[paddr[3:2]] = pwdata[13:0];
            end
            if (hit_vaddr) begin
                next_st.verify_addr = pwdata[12:0];
                next_st.ser_load    = 1'b1;
            end
        end

        // Serial verify: word loaded one cycle after the address settles
        if (st.ser_load && verify_ok) begin
            next_st.ser_shift = prog_mem_rdata;
        end else if (ser_rise && verify_ok) begin
            next_st.ser_shift = {serial_prog_data_in, st.ser_shift[13:1]};
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // Zero-wait slave; answer was prepared in the setup cycle
    assign pready            = 1'b1;
    assign prdata            = st.prdata;
    assign pslverr           = st.pslverr;
    assign tmr0_count_en     = st.tmr0_en;
    assign core_clk_en       = (st.mode == MODE_RUN);
    assign osc_driver_en     = (st.mode == MODE_RUN);
    // Pad logic holds its latches; stopping the core alone would not freeze outputs
    assign io_hold           = (st.mode == MODE_SLEEP);
    assign wake_pulse        = st.wake;
    assign branch_to_vector  = st.vector;
    assign wdt_reset         = st.wdt_reset;
    assign device_reset      = st.device_reset;
    assign time_out_flag_n   = st.to_n;
    assign power_down_flag_n = st.pd_n;
    assign debug_reserve     = !st.cfg_word[`CFG_DEBUG];
    assign debug_mem_base    = `PROG_WORDS - `DEBUG_WORDS;
    assign prog_mem_addr     = st.verify_addr;
    assign serial_prog_data_out  = st.ser_shift[0];
    assign serial_prog_data_oe_n = !verify_ok;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_run_expiry_reset: assert property ((st.mode == MODE_RUN) && expire && !master_clear_pin
        |=> wdt_reset && !time_out_flag_n && !wake_pulse)
        else $error("Run expiry did not reset");
    a_sleep_expiry_wake: assert property ((st.mode == MODE_SLEEP) && expire && !master_clear_pin
        |=> wake_pulse && !wdt_reset && core_clk_en)
        else $error("Sleep expiry did not wake");
    a_expiry_clears_to: assert property (expire && !master_clear_pin |=> !time_out_flag_n)
        else $error("Time-out flag not cleared");
    a_disabled_quiet: assert property (!wdt_on |=> st.wdt_base == 16'h0 && !wdt_reset)
        else $error("Disabled watchdog counted");
    a_cfg_locked: assert property (access_wr && hit_cfg && !prog_mode
        |=> $stable(st.cfg_word))
        else $error("Configuration changed outside program mode");
    a_clear_zeroes: assert property (clear_watchdog_instr && psa_wdt
        |=> st.wdt_base == 16'h0 && st.wdt_post == 8'h0 && $stable(psa_wdt))
        else $error("Clear did not zero watchdog chain");
    a_sleep_entry: assert property (sleep_taken
        |=> io_hold && !osc_driver_en && !power_down_flag_n && time_out_flag_n)
        else $error("Sleep entry effects missing");
    a_sleep_nop: assert property ((st.mode == MODE_RUN) && sleep_instr && pending && !expire && !master_clear_pin
        |=> core_clk_en && $stable(power_down_flag_n) && $stable(time_out_flag_n))
        else $error("Pending interrupt did not make sleep a no-op");
    a_irq_wake: assert property ((st.mode == MODE_SLEEP) && pending && !master_clear_pin && !expire
        |=> wake_pulse && (branch_to_vector == $past(global_irq_enable)))
        else $error("Enabled interrupt did not wake");
    // Master clear may stay low for many cycles, so only the first answer is checked
    a_master_clear_pin_reset: assert property ((st.mode == MODE_SLEEP) && master_clear_pin
        |=> device_reset && !wake_pulse && core_clk_en)
        else $error("Master clear in sleep did not reset");
    a_id_hidden: assert property (psel && !penable && hit_id && !prog_mode
        |=> pslverr && prdata == 32'h0)
        else $error("ID word visible in normal mode");

    // Counting, prescaler sharing and program-mode access
    a_osc_counts: assert property (wdt_on && wdt_osc_tick && !base_wrap
        && !clear_watchdog_instr && !sleep_taken |=> st.wdt_base == $past(st.wdt_base) + 16'h0001)
        else $error("Watchdog base missed a tick");
    a_sleep_clears_chain: assert property (sleep_taken
        |=> st.wdt_base == 16'h0 && (st.wdt_post == 8'h0 || !psa_wdt))
        else $error("Sleep did not clear watchdog chain");
    a_tmr0_prescaled: assert property (tmr0_src_tick && !psa_wdt && st.tmr0_pre == t0_mask
        |=> tmr0_count_en)
        else $error("Timer 0 prescaler missed its count");
    a_id_visible: assert property (psel && !penable && hit_id && prog_mode |=> !pslverr)
        else $error("ID word hidden in program mode");
    a_verify_locked: assert property (psel && !penable && hit_vdata && !verify_ok
        |=> pslverr && prdata == 32'h0)
        else $error("Verify data read while protected");

endmodule

`default_nettype wire

// *** rtl/_unused_marker.sv ***
`timescale 1ns/100ps

// *** dv/wake_source_model.sv ***
// Far-side model: watchdog oscillator ticks and wake-capable interrupt flags
`timescale 1ns/100ps
`default_nettype none
module wake_source_model (
    input  wire logic        pclk,         // Bench clock
    input  wire logic        presetn,      // Reset, active low
    input  wire logic        tick_go,      // Let the oscillator run
    input  wire logic        set_req,      // Raise one flag
    input  wire logic [3:0]  set_idx,      // Which flag
    input  wire logic        clr,          // Drop all flags
    output logic             wdt_osc_tick, // Oscillator tick
    output logic [11:0]      irq_flag      // Flags, held until cleared
);
    // Ticks on alternate cycles whatever the core does; flags stay up as real sources do
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_osc_tick <= 1'b0;
            irq_flag     <= 12'h000;
        end else begin
            wdt_osc_tick <= tick_go & ~wdt_osc_tick;
            if (clr) irq_flag <= 12'h000;
            else if (set_req) irq_flag[set_idx] <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the watchdog and sleep/wake controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; $display("BAD %0t %h %h", $time, a, b); end end
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, tick, go, set_req, clr;
    logic        sleep_instr, clear_watchdog_instr, global_irq_enable, master_clear_pin_n, prog_mode;
    logic        wdt_reset, wake_pulse, branch_to_vector, time_out_flag_n, power_down_flag_n;
    logic        io_hold, core_clk_en, osc_driver_en;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [11:0] irq_enable, flag;
    logic [3:0]  set_idx, idx;
    logic [7:0]  rnd;
    logic [32:0] exp_v;
    logic [32:0] q[$];
    logic        device_reset, debug_reserve, t0en;
    logic [13:0] dbase;
    logic [12:0] vaddr;
    int          err_count, cmp_count, nt, n0, cyc, nt0;
    watchdog_sleep_wake_control #(.WDT_BASE_TICKS(16'h0004)) i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .wdt_osc_tick(tick), .tmr0_src_tick(tick), .tmr0_count_en(t0en), .clear_watchdog_instr,
        .sleep_instr, .global_irq_enable, .irq_flag(flag), .irq_enable, .master_clear_pin_n,
        .prog_mode, .prog_mem_rdata({1'b1, vaddr}), .prog_mem_addr(vaddr), .core_clk_en, .osc_driver_en,
        .io_hold, .wake_pulse, .branch_to_vector, .wdt_reset, .device_reset, .time_out_flag_n,
        .power_down_flag_n, .debug_reserve, .debug_mem_base(dbase), .serial_prog_clk(1'b0),
        .serial_prog_data_in(1'b0), .serial_prog_data_out(), .serial_prog_data_oe_n());
    wake_source_model i_src (.pclk, .presetn, .tick_go(go), .set_req, .set_idx, .clr,
        .wdt_osc_tick(tick), .irq_flag(flag));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic finish_test();
        if (err_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Read notes are queued here; writes hold until pready is seen high
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [32:0] e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One-cycle instruction pulse; outputs are sampled once its edge has landed
    task automatic pulse(input logic slp);
        @(posedge pclk);
        if (slp) sleep_instr <= 1'b1;
        else clear_watchdog_instr <= 1'b1;
        @(posedge pclk);
        sleep_instr <= 1'b0;
        clear_watchdog_instr <= 1'b0;
        #1;
    endtask
    task automatic src(input logic c, input logic [3:0] i);
        @(posedge pclk);
        clr <= c;
        set_req <= !c;
        set_idx <= i;
        @(posedge pclk);
        clr <= 1'b0;
        set_req <= 1'b0;
    endtask
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Oldest note is compared with each completed read
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && q.size() > 0) begin
            exp_v = q.pop_front();
            `CHK({pslverr, prdata}, exp_v)
        end
        if (tick) nt++;
        if (t0en) nt0++;
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, go, set_req, clr, set_idx} = '0;
        {sleep_instr, clear_watchdog_instr, global_irq_enable, prog_mode, irq_enable} = '0;
        master_clear_pin_n = 1'b1;
        rnd = 8'h18;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 16'h0204, 32'h0, {1'b0, 32'h000000ff});
        apb(1'b0, 16'h000c, 32'h0, {1'b0, 32'h00000018});
        apb(1'b0, 16'h0100, 32'h0, {1'b1, 32'h0});
        apb(1'b0, 16'h8000, 32'h0, {1'b1, 32'h0});
        apb(1'b0, 16'h0044, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 16'h801c, 32'h0, 33'h0);
        apb(1'b0, 16'h801c, 32'h0, {1'b0, 32'h000000ff});
        `CHK({debug_reserve, dbase}, 15'h1f00)
        // Program mode: ID word and verify read of the modelled memory word
        rnd = lfsr(rnd);
        @(posedge pclk) prog_mode <= 1'b1;
        apb(1'b1, 16'h8004, {24'h0, rnd}, 33'h0);
        apb(1'b0, 16'h8004, 32'h0, {25'h0, rnd});
        apb(1'b1, 16'h0040, {24'h0, rnd}, 33'h0);
        apb(1'b0, 16'h0044, 32'h0, {19'h0, 6'h20, rnd});
        @(posedge pclk) prog_mode <= 1'b0;
        apb(1'b1, 16'h0204, 32'h0, 33'h0);
        pulse(1'b0);
        apb(1'b0, 16'h0204, 32'h0, {1'b0, 32'h0});
        n0 = nt;
        @(posedge pclk) go <= 1'b1;
        @(posedge wdt_reset) go <= 1'b0;
        #1;
        `CHK(nt - n0, 4)
        `CHK(time_out_flag_n, 1'b0)
        pulse(1'b1);
        `CHK({time_out_flag_n, power_down_flag_n, io_hold, core_clk_en, osc_driver_en}, 5'b10100)
        `CHK(nt0, 2)
        n0 = nt;
        @(posedge pclk) go <= 1'b1;
        @(posedge wake_pulse) go <= 1'b0;
        #1;
        `CHK(nt - n0, 4)
        `CHK({wdt_reset, time_out_flag_n, branch_to_vector, core_clk_en}, 4'b0001)
        rnd = lfsr(rnd);
        idx = 4'(rnd % 8'd12);
        @(posedge pclk) irq_enable <= 12'hfff;
        src(1'b0, idx);
        pulse(1'b1);
        `CHK({time_out_flag_n, core_clk_en, io_hold}, 3'b010)
        src(1'b1, 4'h0);
        global_irq_enable <= 1'b1;
        irq_enable <= 12'h001 << idx;
        pulse(1'b1);
        `CHK({time_out_flag_n, power_down_flag_n, core_clk_en}, 3'b100)
        src(1'b0, 4'((idx + 4'd1) % 4'd12));
        repeat (3) @(posedge pclk);
        #1;
        `CHK(core_clk_en, 1'b0)
        src(1'b0, idx);
        @(posedge wake_pulse);
        #1;
        `CHK(branch_to_vector, 1'b1)
        // Master clear while asleep resets instead of waking
        src(1'b1, 4'h0);
        pulse(1'b1);
        @(posedge pclk) master_clear_pin_n <= 1'b0;
        @(posedge device_reset) #1;
        `CHK({device_reset, core_clk_en, wake_pulse, power_down_flag_n}, 4'b1100)
        @(posedge pclk) master_clear_pin_n <= 1'b1;
        finish_test();
    end
endmodule
`default_nettype wire
